// >>> verilog/tpf_pkg.sv
// Constants and types shared by the transmit packet framer files.
// Summary of operation
// - Shared pin is high-Z by default, status otherwise, serial out while selected.
// - In serial modes during transmit, pin zero is the serial data input.
// - Symbol rate is the link clock times (256 plus mantissa) times 2^exponent over 2^28.
// - Preamble and two or four byte sync are always inserted together.
// - Preamble is alternating ones and zeros, minimum byte count set by a field.
// - Preamble continues past its count until the queue holds data, then sync, data.
// - Sync word is high then low byte, sent twice when repeat mode is 3.
// - Fixed mode uses the programmed length, which the host keeps nonzero.
// - Variable mode takes length from first byte after sync, excluding itself and CRC.
// - Infinite mode runs until host stops it, never in a byte's first half.
// - Fixed and variable packets span one to 255 payload bytes.
// - Control may change in transmit; long packets go infinite then fixed mode.
// - Fixed mode ends when the byte counter reaches the length, then after-state.
// - With checksum enabled, a CRC over queue bytes follows as two bytes.
// - Queue running empty mid-packet enters underrun; only a flush leaves it.
// - Pin select 0x06 flags sync sent to packet end; 0x02, 0x03 show fill level.
// - With four-level modulation, preamble and sync still use two levels.
// - Underrun reports state code 111 until the host flushes.
// - Flush is taken only in idle or underrun; sleep empties the queue in idle only.
package tpf_pkg;
    localparam int Q_AW = 6;
    localparam logic [6:0] Q_FULL = 7'h40;
    localparam logic [6:0] FILL_THRESH = 7'h21;
    localparam logic [7:0] PRE_BYTE = 8'hAA;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [1:0] LEN_FIXED = 2'h0;
    localparam logic [1:0] LEN_VAR = 2'h1;
    localparam logic [1:0] SYNC_REPEAT = 2'h3;
    localparam logic [1:0] SER_PACKET = 2'h0;
    localparam logic [1:0] AFTER_FSON = 2'h1;
    localparam logic [1:0] AFTER_TX = 2'h2;
    localparam logic [5:0] SEL_FILL_THR = 6'h02;
    localparam logic [5:0] SEL_FILL_FULL = 6'h03;
    localparam logic [5:0] SEL_SYNC_PKT = 6'h06;
    localparam logic [5:0] SEL_HIZ = 6'h2E;
    localparam logic [2:0] RS_IDLE = 3'h0;
    localparam logic [2:0] RS_FSON = 3'h1;
    localparam logic [2:0] RS_TX = 3'h2;
    localparam logic [2:0] RS_UFLOW = 3'h7;
    localparam logic [8:0] RATE_BASE = 9'h100;
    localparam int RATE_FRAC = 28;
    localparam int RATE_INC_W = 24;

    typedef enum logic [3:0] {
        F_IDLE = 4'h0,
        F_FSON = 4'h1,
        F_PRE = 4'h2,
        F_SYNC = 4'h3,
        F_DATA = 4'h4,
        F_CRC = 4'h5,
        F_DRAIN = 4'h6,
        F_SER = 4'h7,
        F_UFLOW = 4'h8
    } tpf_fsm_t;

    typedef struct packed {
        logic [7:0] rate_mantissa;
        logic [3:0] rate_exponent;
        logic [7:0] sync_high_byte;
        logic [7:0] sync_low_byte;
        logic [7:0] packet_length_value;
        logic [1:0] packet_length_mode;
        logic checksum_enable;
        logic [1:0] sync_word_repeat_mode;
        logic [2:0] preamble_count_field;
        logic [1:0] after_tx_state_select;
        logic mod_4fsk;
        logic [1:0] serial_mode;
        logic [5:0] sel_zero;
        logic [5:0] sel_shared;
        logic [5:0] sel_two;
    } tpf_cfg_t;

    // Word handed to the link side; it carries the rate so no setting crosses unguarded.
    typedef struct packed {
        logic [7:0] data;
        logic four_level;
        logic [7:0] rate_mantissa;
        logic [3:0] rate_exponent;
    } tpf_word_t;

    function automatic logic [7:0] tpf_pre_bytes(input logic [2:0] f);
        logic [7:0] r;
        unique case (f)
            3'h0: r = 8'h02;
            3'h1: r = 8'h03;
            3'h2: r = 8'h04;
            3'h3: r = 8'h06;
            3'h4: r = 8'h08;
            3'h5: r = 8'h0C;
            3'h6: r = 8'h10;
            3'h7: r = 8'h18;
        endcase
        return r;
    endfunction : tpf_pre_bytes
endpackage : tpf_pkg

// >>> verilog/tpf_rate_nco.sv
// Symbol rate generator: phase accumulator that ticks once per symbol.
`timescale 1ns/1ps
module tpf_rate_nco
    import tpf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] rate_mantissa,
    input wire logic [3:0] rate_exponent,
    output logic tick
);
    typedef struct packed {
        logic [RATE_FRAC-1:0] acc;
        logic tick;
    } tpf_nco_t;

    tpf_nco_t st;
    tpf_nco_t next_st;
    logic [RATE_INC_W-1:0] inc;
    logic [RATE_FRAC:0] sum;

    always_comb begin
        inc = RATE_INC_W'({1'b0, rate_mantissa} + RATE_BASE) << rate_exponent;
        sum = {1'b0, st.acc} + {5'h0, inc};
        next_st.acc = sum[RATE_FRAC-1:0];
        next_st.tick = sum[RATE_FRAC];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    // The increment never exceeds a sixteenth of the wrap, so ticks are isolated.
    a_tick_isolated: assert property (@(posedge clk) disable iff (rst) tick |=> !tick)
        else $error("rate tick on two adjacent cycles");
endmodule : tpf_rate_nco

// >>> verilog/tpf_framer.sv
// Transmit packet framer: TX queue, framing state machine, status pins, link serializer.
`timescale 1ns/1ps
module tpf_framer
    import tpf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire tpf_cfg_t cfg,
    input wire logic tx_start_strobe,
    input wire logic idle_strobe,
    input wire logic flush_tx_queue_strobe,
    input wire logic sleep_strobe,
    input wire logic queue_wr_valid,
    input wire logic [7:0] queue_wr_data,
    output logic queue_wr_ready,
    output logic [6:0] queue_fill,
    output logic [2:0] radio_state,
    input wire logic spi_serial_out,
    input wire logic chip_select_low,
    input wire logic status_out_zero_i,
    output logic status_out_zero_o,
    output logic status_out_zero_oe,
    output logic status_out_shared_o,
    output logic status_out_shared_oe,
    output logic status_out_two_o,
    output logic status_out_two_oe,
    output logic [1:0] tx_symbol,
    output logic tx_symbol_four_level,
    output logic tx_symbol_valid
);
    typedef struct packed {
        tpf_fsm_t fsm;
        logic [63:0][7:0] mem;
        logic [Q_AW-1:0] wp;
        logic [Q_AW-1:0] rp;
        logic [6:0] fill;
        logic [7:0] cnt;
        logic [7:0] len;
        logic first;
        logic [1:0] sidx;
        logic [15:0] crc;
        tpf_word_t xw;
        logic req;
        logic ack_s1;
        logic ack_s2;
        logic busy_s1;
        logic busy_s2;
        logic cs_s1;
        logic cs_s2;
        logic ser_on;
        logic sync_sent;
        logic [2:0] pin_o;
        logic [1:0] pin_oe;
    } tpf_core_t;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic ack;
        logic busy;
        logic [7:0] sh;
        logic [3:0] bits;
        logic fl;
        logic [7:0] rm;
        logic [3:0] re;
        logic ser_s1;
        logic ser_s2;
        logic d0_s1;
        logic d0_s2;
        logic [1:0] sym;
        logic sym4;
        logic symv;
    } tpf_link_t;

    tpf_core_t cs;
    tpf_core_t next_c;
    tpf_link_t ls;
    tpf_link_t next_l;
    logic lrst_s1;
    logic lrst;
    logic tick;
    logic slot;
    logic wr;
    logic pop;
    logic snd;
    logic go_pre;
    logic done;
    logic flush_ok;
    logic [7:0] head;
    logic [7:0] cnt_inc;
    tpf_word_t sw;

    function automatic logic [15:0] tpf_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : tpf_crc_byte

    function automatic logic tpf_pin_sig(input logic [5:0] sel, input logic sync_sent,
                                         input logic [6:0] fill);
        logic r;
        r = 1'b0;
        if (sel == SEL_SYNC_PKT) begin
            r = sync_sent;
        end else if (sel == SEL_FILL_THR) begin
            r = (fill >= FILL_THRESH);
        end else if (sel == SEL_FILL_FULL) begin
            r = (fill == Q_FULL);
        end
        return r;
    endfunction : tpf_pin_sig

    // Core side: queue, framing and pins, all on the crystal clock.
    always_comb begin
        next_c = cs;
        slot = (cs.req == cs.ack_s2);
        wr = queue_wr_valid && queue_wr_ready;
        pop = 1'b0;
        snd = 1'b0;
        go_pre = 1'b0;
        done = 1'b0;
        head = cs.mem[cs.rp];
        cnt_inc = cs.cnt + 8'h01;
        sw.data = PRE_BYTE;
        sw.four_level = 1'b0;
        sw.rate_mantissa = cfg.rate_mantissa;
        sw.rate_exponent = cfg.rate_exponent;
        next_c.ack_s1 = ls.ack;
        next_c.ack_s2 = cs.ack_s1;
        next_c.busy_s1 = ls.busy;
        next_c.busy_s2 = cs.busy_s1;
        next_c.cs_s1 = chip_select_low;
        next_c.cs_s2 = cs.cs_s1;
        flush_ok = (flush_tx_queue_strobe && (cs.fsm == F_IDLE || cs.fsm == F_UFLOW))
            || (sleep_strobe && cs.fsm == F_IDLE);
        unique case (cs.fsm)
            F_IDLE, F_FSON: begin
                if (tx_start_strobe) begin
                    if (cfg.serial_mode != SER_PACKET) begin
                        next_c.fsm = F_SER;
                        next_c.ser_on = 1'b1;
                    end else begin
                        go_pre = 1'b1;
                    end
                end
            end
            F_PRE: begin
                if (slot) begin
                    if (cs.cnt != 8'h00) begin
                        snd = 1'b1;
                        next_c.cnt = cs.cnt - 8'h01;
                    end else if (cs.fill != 7'h00) begin
                        next_c.fsm = F_SYNC;
                    end else begin
                        snd = 1'b1;
                    end
                end
            end
            F_SYNC: begin
                if (slot) begin
                    snd = 1'b1;
                    sw.data = cs.sidx[0] ? cfg.sync_low_byte : cfg.sync_high_byte;
                    next_c.sidx = cs.sidx + 2'h1;
                    if (cs.sidx == 2'h3
                        || (cs.sidx == 2'h1 && cfg.sync_word_repeat_mode != SYNC_REPEAT)) begin
                        next_c.fsm = F_DATA;
                        next_c.sync_sent = 1'b1;
                        next_c.cnt = 8'h00;
                    end
                end
            end
            F_DATA: begin
                if (slot) begin
                    if (cs.fill == 7'h00) begin
                        next_c.fsm = F_UFLOW;
                        next_c.sync_sent = 1'b0;
                    end else begin
                        pop = 1'b1;
                        snd = 1'b1;
                        sw.data = head;
                        sw.four_level = cfg.mod_4fsk;
                        next_c.crc = tpf_crc_byte(cs.crc, head);
                        if (cfg.packet_length_mode == LEN_VAR && cs.first) begin
                            next_c.first = 1'b0;
                            next_c.len = head;
                        end else begin
                            // The counter wraps at 256, so infinite mode keeps a residue.
                            next_c.cnt = cnt_inc;
                            if (cfg.packet_length_mode == LEN_FIXED
                                && cnt_inc == cfg.packet_length_value) begin
                                done = 1'b1;
                            end
                            if (cfg.packet_length_mode == LEN_VAR && cnt_inc == cs.len) begin
                                done = 1'b1;
                            end
                        end
                        if (done) begin
                            next_c.sidx = 2'h0;
                            next_c.fsm = cfg.checksum_enable ? F_CRC : F_DRAIN;
                        end
                    end
                end
            end
            F_CRC: begin
                if (slot) begin
                    snd = 1'b1;
                    sw.four_level = cfg.mod_4fsk;
                    sw.data = cs.sidx[0] ? cs.crc[7:0] : cs.crc[15:8];
                    next_c.sidx = cs.sidx + 2'h1;
                    if (cs.sidx[0]) begin
                        next_c.fsm = F_DRAIN;
                    end
                end
            end
            F_DRAIN: begin
                // Wait for the last byte to leave the serializer before moving on.
                if (slot && !cs.busy_s2) begin
                    next_c.sync_sent = 1'b0;
                    if (cfg.after_tx_state_select == AFTER_FSON) begin
                        next_c.fsm = F_FSON;
                    end else if (cfg.after_tx_state_select == AFTER_TX) begin
                        go_pre = 1'b1;
                    end else begin
                        next_c.fsm = F_IDLE;
                    end
                end
            end
            F_SER: begin
                next_c.ser_on = 1'b1;
            end
            F_UFLOW: begin
                if (flush_tx_queue_strobe) begin
                    next_c.fsm = F_IDLE;
                end
            end
            default: begin
                next_c.fsm = F_IDLE;
            end
        endcase
        if (go_pre) begin
            next_c.fsm = F_PRE;
            next_c.cnt = tpf_pre_bytes(cfg.preamble_count_field);
            next_c.first = 1'b1;
            next_c.crc = CRC_INIT;
            next_c.sidx = 2'h0;
        end
        // A byte already handed over still finishes on the link after a stop.
        if (idle_strobe && cs.fsm != F_IDLE && cs.fsm != F_UFLOW) begin
            next_c.fsm = F_IDLE;
            next_c.ser_on = 1'b0;
            next_c.sync_sent = 1'b0;
        end
        if (snd) begin
            next_c.xw = sw;
            next_c.req = ~cs.req;
        end
        if (wr) begin
            next_c.mem[cs.wp] = queue_wr_data;
            next_c.wp = cs.wp + 6'h01;
        end
        if (pop) begin
            next_c.rp = cs.rp + 6'h01;
        end
        next_c.fill = cs.fill + {6'h00, wr} - {6'h00, pop};
        if (flush_ok) begin
            next_c.rp = next_c.wp;
            next_c.fill = 7'h00;
        end
        next_c.pin_o[0] = tpf_pin_sig(cfg.sel_zero, next_c.sync_sent, next_c.fill);
        next_c.pin_oe[0] = !next_c.ser_on;
        next_c.pin_o[2] = tpf_pin_sig(cfg.sel_two, next_c.sync_sent, next_c.fill);
        if (!cs.cs_s2) begin
            next_c.pin_o[1] = spi_serial_out;
            next_c.pin_oe[1] = 1'b1;
        end else begin
            next_c.pin_o[1] = tpf_pin_sig(cfg.sel_shared, next_c.sync_sent, next_c.fill);
            next_c.pin_oe[1] = (cfg.sel_shared != SEL_HIZ);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cs <= '0;
        end else begin
            cs <= next_c;
        end
    end

    always_comb begin
        unique case (cs.fsm)
            F_IDLE: radio_state = RS_IDLE;
            F_FSON: radio_state = RS_FSON;
            F_UFLOW: radio_state = RS_UFLOW;
            default: radio_state = RS_TX;
        endcase
    end

    assign queue_wr_ready = (cs.fill != Q_FULL);
    assign queue_fill = cs.fill;
    assign status_out_zero_o = cs.pin_o[0];
    assign status_out_zero_oe = cs.pin_oe[0];
    assign status_out_shared_o = cs.pin_o[1];
    assign status_out_shared_oe = cs.pin_oe[1];
    assign status_out_two_o = cs.pin_o[2];
    assign status_out_two_oe = 1'b1;

    // Link side: reset is carried over by two flops, bytes by a toggle handshake.
    always_ff @(posedge link_clk) begin
        lrst_s1 <= rst;
        lrst <= lrst_s1;
    end

    tpf_rate_nco u_nco (
        .clk(link_clk),
        .rst(lrst),
        .rate_mantissa(ls.rm),
        .rate_exponent(ls.re),
        .tick(tick)
    );

    always_comb begin
        next_l = ls;
        next_l.req_s1 = cs.req;
        next_l.req_s2 = ls.req_s1;
        next_l.ser_s1 = cs.ser_on;
        next_l.ser_s2 = ls.ser_s1;
        next_l.d0_s1 = status_out_zero_i;
        next_l.d0_s2 = ls.d0_s1;
        next_l.symv = 1'b0;
        if (tick) begin
            if (ls.ser_s2) begin
                next_l.sym = {1'b0, ls.d0_s2};
                next_l.sym4 = 1'b0;
                next_l.symv = 1'b1;
            end else if (ls.bits != 4'h0) begin
                next_l.symv = 1'b1;
                next_l.sym4 = ls.fl;
                if (ls.fl) begin
                    next_l.sym = ls.sh[7:6];
                    next_l.sh = {ls.sh[5:0], 2'b00};
                    next_l.bits = ls.bits - 4'h2;
                end else begin
                    next_l.sym = {1'b0, ls.sh[7]};
                    next_l.sh = {ls.sh[6:0], 1'b0};
                    next_l.bits = ls.bits - 4'h1;
                end
            end
        end
        // The core holds its word until the acknowledge returns, so it is stable here.
        if (next_l.bits == 4'h0 && ls.req_s2 != ls.ack && !ls.ser_s2) begin
            next_l.sh = cs.xw.data;
            next_l.fl = cs.xw.four_level;
            next_l.rm = cs.xw.rate_mantissa;
            next_l.re = cs.xw.rate_exponent;
            next_l.bits = 4'h8;
            next_l.ack = ~ls.ack;
        end
        next_l.busy = (next_l.bits != 4'h0);
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            ls <= '0;
        end else begin
            ls <= next_l;
        end
    end

    assign tx_symbol = ls.sym;
    assign tx_symbol_four_level = ls.sym4;
    assign tx_symbol_valid = ls.symv;

    sequence s_pre_done;
        cs.fsm == F_PRE && slot && cs.cnt == 8'h00 && cs.fill != 7'h00 && !idle_strobe;
    endsequence
    sequence s_sync_first;
        cs.fsm == F_SYNC && slot && cs.sidx == 2'h0 && !idle_strobe;
    endsequence

    a_pre_to_sync: assert property (@(posedge clk) disable iff (rst)
        s_pre_done |=> cs.fsm == F_SYNC)
        else $error("preamble did not hand over to sync");
    a_pre_pattern: assert property (@(posedge clk) disable iff (rst)
        cs.fsm == F_PRE && slot && cs.cnt != 8'h00
        |=> cs.xw.data == PRE_BYTE && !cs.xw.four_level)
        else $error("preamble byte wrong");
    a_sync_high: assert property (@(posedge clk) disable iff (rst) s_sync_first ##1 1'b1
        |-> cs.xw.data == $past(cfg.sync_high_byte) && !cs.xw.four_level)
        else $error("sync high byte not first");
    a_uflow_hold: assert property (@(posedge clk) disable iff (rst)
        cs.fsm == F_UFLOW && !flush_tx_queue_strobe
        |=> cs.fsm == F_UFLOW && radio_state == RS_UFLOW)
        else $error("underrun left without flush");
    a_flush_empty: assert property (@(posedge clk) disable iff (rst)
        flush_tx_queue_strobe && cs.fsm == F_UFLOW
        |=> cs.fill == 7'h00 && cs.fsm == F_IDLE)
        else $error("flush in underrun did not empty queue");
    a_fixed_end: assert property (@(posedge clk) disable iff (rst)
        cs.fsm == F_DATA && pop && !idle_strobe
        && cfg.packet_length_mode == LEN_FIXED && cnt_inc == cfg.packet_length_value
        |=> cs.fsm == F_CRC || cs.fsm == F_DRAIN)
        else $error("fixed length did not end packet");
    a_empty_uflow: assert property (@(posedge clk) disable iff (rst)
        cs.fsm == F_DATA && slot && cs.fill == 7'h00
        && !idle_strobe |=> cs.fsm == F_UFLOW)
        else $error("empty queue did not underrun");
    a_shared_spi: assert property (@(posedge clk) disable iff (rst) !cs.cs_s2
        |=> status_out_shared_oe && status_out_shared_o == $past(spi_serial_out))
        else $error("shared pin not serial output while selected");
    a_msb_first: assert property (@(posedge link_clk) disable iff (lrst)
        ls.symv && !ls.sym4 && !$past(ls.ser_s2) |-> ls.sym[0] == $past(ls.sh[7]))
        else $error("symbol not taken from top bit");
endmodule : tpf_framer

// >>> tb/tpf_host_model.sv
// Host side model that pushes bytes into the transmit queue.
`timescale 1ns/1ps
module tpf_host_model (
    input wire logic clk,
    input wire logic ready,
    output logic valid,
    output logic [7:0] data
);
    initial valid = 1'b0;
    initial data = 8'h00;
    // Called just after an edge; holds the byte until ready is seen at an edge.
    // Ready is read between edges, where it is settled, and an idle edge follows
    // each byte so that back to back calls never touch valid twice in one step.
    task automatic send(input logic [7:0] b);
        logic rdy;
        valid = 1'b1;
        data = b;
        forever begin
            rdy = ready;
            @(posedge clk);
            #1;
            if (rdy === 1'b1) break;
        end
        valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : send
endmodule : tpf_host_model

// >>> tb/tx_packet_framer_modulator_ctl_test.sv
// Self-checking bench for the transmit packet framer.
`timescale 1ns/1ps
module tx_packet_framer_modulator_ctl_test
    import tpf_pkg::*;
;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    tpf_cfg_t cfg = '0;
    logic start = 1'b0;
    logic idle_s = 1'b0;
    logic flush = 1'b0;
    logic sleep = 1'b0;
    logic cs_low = 1'b1;
    logic spi_so = 1'b0;
    logic wr_v, wr_r, z_o, z_oe, s_o, s_oe, t_o, t_oe, sym_4, sym_v;
    logic [7:0] wr_d;
    logic [7:0] sh;
    logic [6:0] fill;
    logic [2:0] st;
    logic [1:0] sym;
    logic [7:0] rxq[$];
    logic seen = 1'b0;
    int nb = 0;
    int cyc = 0;
    int error_cnt = 0;
    int check_count = 0;
    initial forever #2 clk = ~clk;
    initial begin
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    tpf_framer u_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .cfg(cfg),
        .tx_start_strobe(start), .idle_strobe(idle_s), .flush_tx_queue_strobe(flush),
        .sleep_strobe(sleep), .queue_wr_valid(wr_v), .queue_wr_data(wr_d),
        .queue_wr_ready(wr_r), .queue_fill(fill), .radio_state(st),
        .spi_serial_out(spi_so), .chip_select_low(cs_low), .status_out_zero_i(1'b0),
        .status_out_zero_o(z_o), .status_out_zero_oe(z_oe), .status_out_shared_o(s_o),
        .status_out_shared_oe(s_oe), .status_out_two_o(t_o), .status_out_two_oe(t_oe),
        .tx_symbol(sym), .tx_symbol_four_level(sym_4), .tx_symbol_valid(sym_v));
    tpf_host_model u_host (.clk(clk), .ready(wr_r), .valid(wr_v), .data(wr_d));
    // Two-level symbols carry one bit each; bytes are rebuilt from the link stream.
    // Sampled on the falling edge, half a cycle after the symbol is launched.
    always @(negedge link_clk) begin
        if (sym_v) begin
            sh = {sh[6:0], sym[0]};
            nb++;
            if (nb == 8) begin
                rxq.push_back(sh);
                nb = 0;
            end
        end
    end
    always @(posedge clk) begin
        cyc++;
        seen <= seen | z_o;
        if (cyc == 80000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : compare
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 20000 && st !== s; i++) tick(1);
        compare(st, s);
    endtask : wait_st
    function automatic logic [15:0] crc16(input logic [7:0] d[$]);
        logic [15:0] c = CRC_INIT;
        foreach (d[i])
            for (int b = 7; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ (c[15] ^ d[i][b] ? CRC_POLY : 16'h0);
        return c;
    endfunction : crc16
    task automatic pkt(input logic [1:0] m, input logic [7:0] len, input logic crc,
                       input logic [1:0] rep, input logic [7:0] q[$]);
        logic [7:0] exp[$];
        logic [15:0] c;
        int n = 0;
        cfg.packet_length_mode = m;
        cfg.packet_length_value = len;
        cfg.checksum_enable = crc;
        cfg.sync_word_repeat_mode = rep;
        rxq.delete();
        nb = 0;
        seen = 1'b0;
        pulse(start);
        compare(st, RS_TX);
        // The queue stays empty long enough for several extra preamble bytes.
        tick(3000);
        foreach (q[i]) u_host.send(q[i]);
        wait_st(RS_IDLE);
        // The last symbol reaches the capture half a link cycle after launch, before the state settles.
        tick(20);
        exp = {8'hD3, 8'h91};
        if (rep == SYNC_REPEAT) exp = {exp, exp};
        c = crc16(q);
        exp = {exp, q};
        if (crc) exp = {exp, c[15:8], c[7:0]};
        while (rxq.size() > 0 && rxq[0] === PRE_BYTE) begin
            void'(rxq.pop_front());
            n++;
        end
        compare(16'(n > 3), 16'h1);
        compare(16'(rxq.size()), 16'(exp.size()));
        foreach (exp[i]) compare(rxq[i], exp[i]);
        compare(seen, 1'b1);
    endtask : pkt
    task automatic fill_up;
        repeat (64) u_host.send(8'hC3);
        compare({wr_r, fill}, 8'h40);
        compare(t_o, 1'b1);
        pulse(flush);
        compare(fill, 7'h00);
        u_host.send(8'h01);
        pulse(sleep);
        compare(fill, 7'h00);
    endtask : fill_up
    task automatic pins;
        compare(s_oe, 1'b0);
        cs_low = 1'b0;
        spi_so = 1'b1;
        tick(5);
        compare({s_oe, s_o}, 2'b11);
        cs_low = 1'b1;
        cfg.sel_shared = SEL_FILL_FULL;
        tick(5);
        compare({s_oe, s_o}, 2'b10);
    endtask : pins
    task automatic underrun;
        cfg.packet_length_mode = LEN_FIXED;
        cfg.packet_length_value = 8'h04;
        u_host.send(8'h5A);
        pulse(start);
        wait_st(RS_UFLOW);
        u_host.send(8'h66);
        tick(2000);
        compare({st, fill}, {RS_UFLOW, 7'h01});
        pulse(flush);
        compare({st, fill}, {RS_IDLE, 7'h00});
    endtask : underrun
    task automatic print_verdict;
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial begin
        cfg.rate_mantissa = 8'hFF;
        cfg.preamble_count_field = 3'h2;
        cfg.rate_exponent = 4'hF;
        cfg.sync_high_byte = 8'hD3;
        cfg.sync_low_byte = 8'h91;
        cfg.sel_zero = SEL_SYNC_PKT;
        cfg.sel_shared = SEL_HIZ;
        cfg.sel_two = SEL_FILL_THR;
        // Reset spans several link edges so the link side is cleared too.
        tick(12);
        rst = 1'b0;
        tick(20);
        pins();
        fill_up();
        pkt(LEN_FIXED, 8'h03, 1'b1, SYNC_REPEAT, {8'h11, 8'h22, 8'h33});
        pkt(LEN_VAR, 8'h05, 1'b0, 2'h0, {8'h02, 8'hA5, 8'h3C});
        underrun();
        print_verdict();
    end
endmodule : tx_packet_framer_modulator_ctl_test
